// ==== rtl/bmw_map.vh ====
`ifndef BMW_MAP_VH
`define BMW_MAP_VH
// register addresses in external data space
`define BMW_ADDR_ROM_SHADOW   16'hFF90
`define BMW_ADDR_WATCHDOG     16'hFF93
// rom_shadow_config fields
`define BMW_RSC_SHADOW_BIT    0
`define BMW_RSC_SIZE_CODE     2'h2
`define BMW_RSC_RAM_FLAG      1'h1
`define BMW_RSC_RESERVED      4'h0
// watchdog_control_status fields
`define BMW_WD_KICK_BIT       0
`define BMW_WD_FLAG_BIT       6
`define BMW_WD_LOW_BIT        7
`define BMW_WD_HIGH_RESET     5'h00
`define BMW_WD_LOW_RESET      1'h1
`define BMW_WD_DISABLE_HIGH   5'h15
`define BMW_WD_DISABLE_LOW    1'h0
// watchdog timing
`define BMW_WD_TICK_MS        1
`define BMW_WD_TIMEOUT_MS     128
`define BMW_WD_WIDTH          7
// memory map
`define BMW_ROM_LOW_BASE      16'h0000
`define BMW_ROM_LOW_LAST      16'h27FF
`define BMW_ROM_HIGH_BASE     16'h8000
`define BMW_ROM_HIGH_LAST     16'hA7FF
`define BMW_RAM_BASE          16'h0000
`define BMW_RAM_LAST          16'h3FFF
`define BMW_IO_BASE           16'hF800
`define BMW_IO_LAST           16'hFFFF
`endif

// ==== rtl/bmw_boot_map_watchdog.v ====
// Function
// [R1] boot mode: rom at code 0000-27FF and 8000-A7FF, ram at data 0000-3FFF
// [R2] normal mode: rom only at code 8000-A7FF, ram in code from 0000
// [R3] buffers, registers and io in data space F800-FFFF in both modes
// [R4] normal mode ram is code-only read-only; boot mode ram is data read/write
// [R5] shadow select resets to 0, set by write, cleared only by reset or timeout
// [R6] shadow config bits 4-1 always read 0000b
// [R7] code-size field bits 6-5 hardwired to 10b, meaning 16K
// [R8] bit 7 of shadow config is constant 1, code space is ram
// [R9] reset clears shadow select and connect bit; first fetch from boot rom 0000h
// [R10] firmware checks eeprom signature, loads ram via data space, else usb
// [R11] firmware sets shadow select first, then the connect bit
// [R12] watchdog ticks on 1-ms frame pulses, only while connected
// [R13] 7-bit millisecond counter resets device after 128 ms without a kick
// [R14] writing 1 to bit 0 kicks the watchdog; reads as 0
// [R15] watchdog disabled only by bits 5-1 = 10101b with bit 7 = 0
// [R16] bit 6 is 0 after power-up, 1 after timeout; write 1 clears it
// [R17] kick zeroes the counter; counter held at zero while disabled
`timescale 1ns/1ps
`include "bmw_map.vh"
module bmw_boot_map_watchdog #(
  parameter WD_WIDTH = `BMW_WD_WIDTH
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [15:0] code_addr,
  input  wire [15:0] data_addr,
  input  wire        data_wr,
  input  wire        data_rd,
  input  wire [7:0]  data_wdata,
  input  wire        usb_connect_bit,
  input  wire        frame_tick,
  output reg  [7:0]  reg_rdata,
  output reg         reg_hit,
  output reg         code_rom_sel,
  output reg         code_ram_sel,
  output reg  [13:0] code_ram_addr,
  output reg  [13:0] code_rom_addr,
  output reg         data_ram_sel,
  output reg         data_ram_we,
  output reg         data_io_sel,
  output reg         shadow_select,
  output reg         watchdog_reset
);

  // the count runs 0..WD_LAST; the step taken at WD_LAST is the timeout
  localparam integer        WD_LAST_INT = `BMW_WD_TIMEOUT_MS / `BMW_WD_TICK_MS - 1;
  localparam [WD_WIDTH-1:0] WD_LAST     = WD_LAST_INT[WD_WIDTH-1:0];
  localparam [WD_WIDTH-1:0] WD_ZERO     = {WD_WIDTH{1'b0}};
  localparam integer        SYNC_LANES  = 2;
  localparam integer        LANE_TICK   = 0;
  localparam integer        LANE_CONN   = 1;

  // inclusive address window test shared by the code and data window decodes
  function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // exact match of a data address against one register location
  function reg_match;
    input [15:0] a;
    input [15:0] loc;
    begin
      reg_match = (a == loc);
    end
  endfunction

  // byte image of rom_shadow_config; only bit 0 is state
  function [7:0] shadow_image;
    input sel;
    begin
      shadow_image = {`BMW_RSC_RAM_FLAG, `BMW_RSC_SIZE_CODE, `BMW_RSC_RESERVED, sel};
    end
  endfunction

  // byte image of watchdog_control_status; the kick bit never reads back
  function [7:0] watchdog_image;
    input       low;
    input       flag;
    input [4:0] high;
    begin
      watchdog_image = {low, flag, high, 1'b0};
    end
  endfunction

  reg                   watchdog_disable_low;
  reg  [4:0]            watchdog_disable_high;
  reg                   watchdog_reset_flag;
  reg  [WD_WIDTH-1:0]   wd_count;
  reg                   tick_prev;
  reg                   timeout_seen;
  reg                   next_tick_prev;
  reg                   next_timeout;
  reg                   next_shadow_select;
  reg                   next_disable_low;
  reg  [4:0]            next_disable_high;
  reg                   next_reset_flag;
  reg  [WD_WIDTH-1:0]   next_wd_count;
  reg  [7:0]            next_reg_rdata;
  reg                   next_reg_hit;
  reg                   next_code_rom_sel;
  reg                   next_code_ram_sel;
  reg                   next_data_ram_sel;
  reg                   next_data_ram_we;
  reg                   next_data_io_sel;
  wire [SYNC_LANES-1:0] async_in;
  wire [SYNC_LANES-1:0] sync_out;

  // register strobes; a write lands on the edge that sees data_wr high
  wire       rd_rom_shadow = data_rd && reg_match(data_addr, `BMW_ADDR_ROM_SHADOW);
  wire       rd_watchdog   = data_rd && reg_match(data_addr, `BMW_ADDR_WATCHDOG);
  wire       wr_rom_shadow = data_wr && reg_match(data_addr, `BMW_ADDR_ROM_SHADOW);
  wire       wr_watchdog   = data_wr && reg_match(data_addr, `BMW_ADDR_WATCHDOG);
  wire       set_shadow    = wr_rom_shadow && data_wdata[`BMW_RSC_SHADOW_BIT];
  wire       kick          = wr_watchdog && data_wdata[`BMW_WD_KICK_BIT]; // R14
  wire       clear_flag    = wr_watchdog && data_wdata[`BMW_WD_FLAG_BIT];

  // all six bits must match, so a half-written pattern keeps the timer running
  wire [5:0] watchdog_disable_code = {watchdog_disable_high, watchdog_disable_low};
  wire       wd_disabled   = (watchdog_disable_code ==
                             {`BMW_WD_DISABLE_HIGH, `BMW_WD_DISABLE_LOW}); // R15

  wire       tick_sync     = sync_out[LANE_TICK];
  wire       conn_sync     = sync_out[LANE_CONN];
  // a frame tick only counts while the host link is up
  wire       tick_rise     = tick_sync && !tick_prev;
  wire       wd_step       = !wd_disabled && conn_sync && tick_rise; // R12
  wire       expire        = wd_step && (wd_count == WD_LAST); // R13
  // any reset (external or watchdog) restores boot state
  wire       any_rst       = rst || timeout_seen;

  wire       code_in_ram   = in_range(code_addr, `BMW_RAM_BASE, `BMW_RAM_LAST);
  wire       code_in_low   = in_range(code_addr, `BMW_ROM_LOW_BASE, `BMW_ROM_LOW_LAST);
  wire       code_in_high  = in_range(code_addr, `BMW_ROM_HIGH_BASE, `BMW_ROM_HIGH_LAST);
  wire       data_access   = data_rd || data_wr;
  wire       data_in_ram   = in_range(data_addr, `BMW_RAM_BASE, `BMW_RAM_LAST);
  wire       data_in_io    = in_range(data_addr, `BMW_IO_BASE, `BMW_IO_LAST);

  assign async_in = {usb_connect_bit, frame_tick};

  // two flops per asynchronous input; only the second flop is read
  genvar lane;
  generate
    for (lane = 0; lane < SYNC_LANES; lane = lane + 1) begin : g_sync
      reg meta;
      reg stable;
      always @(posedge clk) begin
        meta   <= async_in[lane];
        stable <= meta;
      end
      assign sync_out[lane] = stable;
    end
  endgenerate

  // starts at the idle level of the tick so reset leaves no false edge
  always @* begin
    next_tick_prev = tick_sync;
    if (rst) begin
      next_tick_prev = 1'b0;
    end
  end

  always @(posedge clk) begin
    tick_prev <= next_tick_prev;
  end

  always @* begin
    next_timeout = expire; // R13
    if (rst) begin
      next_timeout = 1'b0;
    end
  end

  // timeout pulses a one-cycle device reset; the flag survives it
  always @(posedge clk) begin
    timeout_seen <= next_timeout;
  end

  // the pulse leaves the block so the core and the connect bit reset with it
  always @(posedge clk) begin
    watchdog_reset <= next_timeout; // R13
  end

  // software can only set the select bit; clearing needs a reset
  always @* begin
    next_shadow_select = shadow_select;
    if (any_rst) begin
      next_shadow_select = 1'b0; // R5 R9
    end else if (set_shadow) begin
      next_shadow_select = 1'b1; // R5 R11
    end
  end

  always @(posedge clk) begin
    shadow_select <= next_shadow_select;
  end

  always @* begin
    next_disable_high = watchdog_disable_high;
    next_disable_low  = watchdog_disable_low;
    if (any_rst) begin
      next_disable_high = `BMW_WD_HIGH_RESET;
      next_disable_low  = `BMW_WD_LOW_RESET;
    end else if (wr_watchdog) begin
      next_disable_high = data_wdata[5:1]; // R15
      next_disable_low  = data_wdata[`BMW_WD_LOW_BIT]; // R15
    end
  end

  always @(posedge clk) begin
    watchdog_disable_high <= next_disable_high;
  end

  always @(posedge clk) begin
    watchdog_disable_low <= next_disable_low;
  end

  // set by a timeout beats a same-cycle software clear
  always @* begin
    next_reset_flag = watchdog_reset_flag;
    if (rst) begin
      next_reset_flag = 1'b0; // R16
    end else if (expire) begin
      next_reset_flag = 1'b1; // R16
    end else if (clear_flag) begin
      next_reset_flag = 1'b0; // R16
    end
  end

  always @(posedge clk) begin
    watchdog_reset_flag <= next_reset_flag;
  end

  // the count wraps from WD_LAST to zero on the expiring step; the timeout reset then keeps it there
  always @* begin
    next_wd_count = wd_count;
    if (any_rst || wd_disabled || kick) begin
      next_wd_count = WD_ZERO; // R17
    end else if (wd_step) begin
      next_wd_count = wd_count + 1'b1; // R12 R13
    end
  end

  always @(posedge clk) begin
    wd_count <= next_wd_count;
  end

  // unmapped reads return zero so a stale byte cannot pass for a register
  always @* begin
    next_reg_hit   = rd_rom_shadow || rd_watchdog;
    next_reg_rdata = 8'h00;
    if (rd_rom_shadow) begin
      next_reg_rdata = shadow_image(shadow_select); // R6 R7 R8
    end else if (rd_watchdog) begin
      next_reg_rdata = watchdog_image(watchdog_disable_low, watchdog_reset_flag,
                                      watchdog_disable_high); // R14 R16
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_hit <= 1'b0;
    end else begin
      reg_hit <= next_reg_hit;
    end
  end

  // code-side decode; the ram is visible as code only in normal mode
  always @* begin
    next_code_rom_sel = 1'b0;
    next_code_ram_sel = 1'b0;
    if (shadow_select) begin
      next_code_rom_sel = code_in_high; // R2
      next_code_ram_sel = code_in_ram; // R2 R4
    end else begin
      next_code_rom_sel = code_in_low || code_in_high; // R1 R9
    end
  end

  // data-side decode; normal mode hides the ram from data space, blocking writes
  always @* begin
    next_data_ram_sel = 1'b0;
    next_data_ram_we  = 1'b0;
    next_data_io_sel  = data_access && data_in_io; // R3
    if (!shadow_select) begin
      next_data_ram_sel = data_access && data_in_ram; // R1 R4 R10
      next_data_ram_we  = data_wr && data_in_ram; // R4 R10
    end
  end

  // registered decode costs a cycle but keeps the selects glitch-free
  always @(posedge clk) begin
    if (rst) begin
      code_rom_sel  <= 1'b0;
      code_ram_sel  <= 1'b0;
      code_ram_addr <= 14'h0000;
      code_rom_addr <= 14'h0000;
    end else begin
      code_rom_sel  <= next_code_rom_sel;
      code_ram_sel  <= next_code_ram_sel;
      // both rom windows share the low 14 bits; the high copy only adds bit 15
      code_rom_addr <= code_addr[13:0];
      code_ram_addr <= code_addr[13:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      data_ram_sel <= 1'b0;
      data_ram_we  <= 1'b0;
      data_io_sel  <= 1'b0;
    end else begin
      data_ram_sel <= next_data_ram_sel;
      data_ram_we  <= next_data_ram_we;
      data_io_sel  <= next_data_io_sel;
    end
  end

endmodule

// ==== verif/bmw_chk_checker.sv ====
`timescale 1ns/1ps
module bmw_chk #(parameter WD_WIDTH = 7) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] code_addr,
  input wire logic [15:0] data_addr,
  input wire logic        data_wr,
  input wire logic        data_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_hit,
  input wire logic        code_rom_sel,
  input wire logic        code_ram_sel,
  input wire logic        data_ram_sel,
  input wire logic        data_ram_we,
  input wire logic [13:0] code_ram_addr,
  input wire logic [13:0] code_rom_addr,
  input wire logic        data_io_sel,
  input wire logic        shadow_select,
  input wire logic        watchdog_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd90; data_rd && data_addr == 16'hFF90; endsequence
  property p_fix; s_rd90 |=> reg_hit && reg_rdata[7:1] == 7'h60; endproperty
  a_fix: assert property (p_fix) else $error("fixed bits wrong");
  property p_sdw; s_rd90 |=> reg_rdata[0] == $past(shadow_select); endproperty
  a_sdw: assert property (p_sdw) else $error("select bit misread");
  // a sync reset lets the select bit fall one edge after rst was seen
  property p_clr; $fell(shadow_select) |-> watchdog_reset || $past(watchdog_reset) || $past(rst); endproperty
  a_clr: assert property (p_clr) else $error("select bit cleared");
  property p_boot; !shadow_select && code_addr < 16'h2800 |=> code_rom_sel && !code_ram_sel; endproperty
  a_boot: assert property (p_boot) else $error("boot decode wrong");
  property p_norm; shadow_select && code_addr < 16'h4000 |=> code_ram_sel && !code_rom_sel; endproperty
  a_norm: assert property (p_norm) else $error("normal decode wrong");
  property p_io; (data_rd || data_wr) && data_addr >= 16'hF800 |=> data_io_sel; endproperty
  a_io: assert property (p_io) else $error("io decode wrong");
  property p_we; data_wr && data_addr < 16'h4000 |=> data_ram_we == !$past(shadow_select); endproperty
  a_we: assert property (p_we) else $error("ram write wrong");
  property p_kick; data_rd && data_addr == 16'hFF93 |=> reg_hit && !reg_rdata[0]; endproperty
  a_kick: assert property (p_kick) else $error("kick bit read 1");
  logic [13:0] code_low;
  assign code_low = code_addr[13:0];
  property p_pulse; watchdog_reset |=> !watchdog_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_wdclr; watchdog_reset |=> !shadow_select; endproperty
  a_wdclr: assert property (p_wdclr) else $error("select kept after timeout");
  property p_ram; !shadow_select && (data_rd || data_wr) && data_addr < 16'h4000 |=> data_ram_sel; endproperty
  a_ram: assert property (p_ram) else $error("boot ram select wrong");
  property p_addr; 1'b1 |=> code_ram_addr == $past(code_low) && code_rom_addr == $past(code_low); endproperty
  a_addr: assert property (p_addr) else $error("code address wrong");
endmodule
bind bmw_boot_map_watchdog bmw_chk #(.WD_WIDTH(WD_WIDTH)) i_bmw_chk (.*);

// ==== verif/bmw_cpu.sv ====
`timescale 1ns/1ps
module bmw_cpu (
  input  wire logic        clk,
  input  wire logic [7:0]  reg_rdata,
  output logic      [15:0] data_addr = 16'h0000,
  output logic             data_wr = 1'h0,
  output logic             data_rd = 1'h0,
  output logic      [7:0]  data_wdata = 8'h00
);
  // kick is a write of 1 to bit 0; released data is inverted so stale bytes never look valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 data_addr = a;
    data_wdata = d;
    data_wr = 1'h1;
    @(posedge clk);
    #1 data_wr = 1'h0;
    data_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 data_addr = a;
    data_rd = 1'h1;
    @(posedge clk);
    #1 data_rd = 1'h0;
    d = reg_rdata;
  endtask
endmodule

// ==== verif/bmw_boot_map_watchdog_tb.sv ====
`timescale 1ns/1ps
module bmw_boot_map_watchdog_tb;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        usb_connect_bit = 1'h0;
  logic        frame_tick = 1'h0;
  logic [15:0] code_addr = 16'h0000;
  logic [15:0] data_addr;
  logic        data_wr, data_rd, reg_hit, code_ram_sel, shadow_select, watchdog_reset;
  logic [7:0]  data_wdata, reg_rdata, v;
  logic [7:0]  pulses = 8'h00;
  int          fail_count = 0;
  int          checked = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (watchdog_reset === 1'h1) pulses <= pulses + 8'h01;
  bmw_boot_map_watchdog i_bmw_boot_map_watchdog (.clk, .rst, .code_addr, .data_addr, .data_wr, .data_rd,
    .data_wdata, .usb_connect_bit, .frame_tick, .reg_rdata, .reg_hit, .code_rom_sel(), .code_ram_sel,
    .code_ram_addr(), .code_rom_addr(), .data_ram_sel(), .data_ram_we(), .data_io_sel(), .shadow_select,
    .watchdog_reset);
  bmw_cpu i_bmw_cpu (.clk, .reg_rdata, .data_addr, .data_wr, .data_rd, .data_wdata);
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task rc(input logic [15:0] a, input logic [7:0] e);
    i_bmw_cpu.rd(a, v);
    chk(v, e);
  endtask
  // slow ticks, then settle so the two-stage sync has surely passed the last edge
  task ticks(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk);
      #1 frame_tick = ~frame_tick;
      repeat (3) @(posedge clk);
      #1 frame_tick = ~frame_tick;
    end
    repeat (6) @(posedge clk);
    #1;
  endtask
  task summarize;
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'h0;
    rc(16'hFF90, 8'hC0);
    rc(16'hFF93, 8'h80);
    i_bmw_cpu.wr(16'h0010, 8'h5A);
    i_bmw_cpu.wr(16'hFF90, 8'hFF);
    rc(16'hFF90, 8'hC1);
    i_bmw_cpu.wr(16'hFF90, 8'h00);
    rc(16'hFF90, 8'hC1);
    code_addr = 16'h0100;
    repeat (2) @(posedge clk);
    chk({7'h00, code_ram_sel}, 8'h01);
    i_bmw_cpu.wr(16'h0010, 8'hA5);
    i_bmw_cpu.wr(16'hF900, 8'h11);
    ticks(130);
    chk(pulses, 8'h00);
    usb_connect_bit = 1'h1;
    ticks(100);
    i_bmw_cpu.wr(16'hFF93, 8'h01);
    ticks(127);
    chk(pulses, 8'h00);
    ticks(1);
    chk(pulses, 8'h01);
    chk({7'h00, shadow_select}, 8'h00);
    rc(16'hFF93, 8'hC0);
    i_bmw_cpu.wr(16'hFF93, 8'hC0);
    rc(16'hFF93, 8'h80);
    i_bmw_cpu.wr(16'hFF93, 8'h2A);
    rc(16'hFF93, 8'h2A);
    ticks(200);
    chk(pulses, 8'h01);
    summarize;
  end
  initial begin
    #60000;
    fail_count++;
    summarize;
  end
endmodule
